// [hdl/rbm_pkg.sv]
// constants and types shared by the rtc register/buffer map
// ------------------------------------------------------------
// Notes on behaviour
// - sixteen byte registers in one address space
// - clock counters via buffers, others direct
// - time and alarm fields kept in BCD
// - buffers track counters while bus idle
// - transaction start freezes buffer refresh
// - one snapshot for whole read sequence
// - bits at rising edge, byte at eighth
// - clock writes held until pointer 8/stop
// - commit loads all counters at once
// - minutes D7 is osc-fail irq enable
// - reg 04h: rate, zero, weekday
// - reg 06h: century, zero, month tens/units
// - watchdog resolution and multiplier layout
// - reg 0Ah D7 alarm irq enable
// - square-wave enable at 0Ah D6
// - five alarm repeat bits in 0Bh-0Eh
// - alarm flag D6, host cannot write
// - watchdog flag D7, host cannot write
// - osc-fail flag D2, rest zero
// - khz enable 0Ah D5 in square variant
// - seconds D7 halts the oscillator
// - trim magnitude, sign, idle level in 08h
// - clock write forces sub-second to 00
// - pointer advances after each data byte
// ------------------------------------------------------------
package rbm_pkg;

	typedef enum logic [1:0] {RBM_FULL, RBM_WAVE, RBM_ALARM} rbm_variant_t;

	localparam int          REG_COUNT   = 16;
	localparam int          CLOCK_REGS  = 8;
	localparam logic [3:0]  REG_SUBSEC  = 4'h0;
	localparam logic [3:0]  REG_SECONDS = 4'h1;
	localparam logic [3:0]  REG_MINUTES = 4'h2;
	localparam logic [3:0]  REG_HOURS   = 4'h3;
	localparam logic [3:0]  REG_WEEKDAY = 4'h4;
	localparam logic [3:0]  REG_MDAY    = 4'h5;
	localparam logic [3:0]  REG_CENMON  = 4'h6;
	localparam logic [3:0]  REG_YEAR    = 4'h7;
	localparam logic [3:0]  REG_TRIM    = 4'h8;
	localparam logic [3:0]  REG_TIMEOUT = 4'h9;
	localparam logic [3:0]  REG_ALMON   = 4'ha;
	localparam logic [3:0]  REG_ALDAY   = 4'hb;
	localparam logic [3:0]  REG_ALHOUR  = 4'hc;
	localparam logic [3:0]  REG_ALMIN   = 4'hd;
	localparam logic [3:0]  REG_ALSEC   = 4'he;
	localparam logic [3:0]  REG_STATUS  = 4'hf;
	localparam logic [3:0]  LAST_CLOCK  = 4'h7;

	// bit positions
	localparam int HALT_BIT      = 7;
	localparam int FAIL_IRQ_BIT  = 7;
	localparam int ALARM_IRQ_BIT = 7;
	localparam int WAVE_EN_BIT   = 6;
	localparam int KHZE_BIT      = 5;
	localparam int OUT_BIT       = 7;
	localparam int SIGN_BIT      = 5;
	localparam int TIMEOUT_BIT   = 7;
	localparam int ALARM_BIT     = 6;
	localparam int FAIL_BIT      = 2;

	// writable bits, byte i at [8*i +: 8]; zeros are fixed-zero or read-only positions
	localparam logic [127:0] WMASK_FULL  = 128'h00_ff_ff_bf_ff_df_ff_bf_ff_df_3f_f7_3f_ff_ff_ff;
	localparam logic [127:0] WMASK_WAVE  = 128'h00_ff_ff_bf_ff_7f_ff_3f_ff_df_3f_f7_3f_7f_ff_ff;
	localparam logic [127:0] WMASK_ALARM = 128'h00_ff_ff_bf_ff_9f_ff_ff_ff_df_3f_07_3f_ff_ff_ff;

	// BCD counter limits
	localparam logic [7:0] CENTI_LAST = 8'h99;
	localparam logic [7:0] MINSEC_LAST = 8'h59;
	localparam logic [7:0] HOUR_LAST  = 8'h23;
	localparam logic [7:0] DOW_LAST   = 8'h07;
	localparam logic [7:0] MONTH_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST  = 8'h99;
	localparam logic [7:0] BCD_ZERO   = 8'h00;
	localparam logic [7:0] BCD_ONE    = 8'h01;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] BIT_LAST   = 3'h7;

endpackage

// [hdl/rbm_regmap.sv]
// rtc register map: buffer/transfer registers, counters, direct registers
`timescale 1ns/1ns
module rbm_regmap #(
	parameter rbm_pkg::rbm_variant_t VARIANT = rbm_pkg::RBM_FULL
) (
	// core clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// link side, clocked by the bus clock
	input  wire logic       link_clk_i,
	input  wire logic       sda_i,
	input  wire logic       frame_i,
	input  wire logic       byte_wr_i,
	input  wire logic       addr_byte_i,
	input  wire logic       rd_ack_i,
	output logic      [7:0] rd_data_o,
	// pins from oscillator, watchdog and alarm logic
	input  wire logic       centi_tick_i,
	input  wire logic       watchdog_timeout_i,
	input  wire logic       alarm_hit_i,
	input  wire logic       osc_fail_i,
	// control outputs
	output logic            divider_reset_o,
	output logic            oscillator_halt_o,
	output logic            osc_fail_irq_enable_o,
	output logic      [3:0] square_wave_rate_o,
	output logic            square_wave_enable_o,
	output logic            khz_output_enable_o,
	output logic            alarm_irq_enable_o,
	output logic      [4:0] alarm_repeat_mode_o,
	output logic      [4:0] watchdog_multiplier_o,
	output logic      [2:0] watchdog_resolution_o,
	output logic      [4:0] trim_value_o,
	output logic            trim_sign_o,
	output logic            idle_level_o,
	output logic      [1:0] century_bits_o,
	output logic            frozen_o
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [7:0] wmask(input logic [3:0] idx);
		logic [127:0] m;
		m = rbm_pkg::WMASK_FULL;
		case (VARIANT)
			rbm_pkg::RBM_WAVE:  m = rbm_pkg::WMASK_WAVE;
			rbm_pkg::RBM_ALARM: m = rbm_pkg::WMASK_ALARM;
			default:            m = rbm_pkg::WMASK_FULL;
		endcase
		return m[{idx, 3'h0} +: 8];
	endfunction

	// {wrap, next} of a packed BCD count
	function automatic logic [8:0] bcd_next(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
		if (v >= last)
			return {1'b1, first};
		else if (v[3:0] == 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_days(input logic [4:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			5'h02:                      return leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
			default:                    return 8'h31;
		endcase
	endfunction

	// ------------------------------------------------------------
	// link domain: shift in, byte and ack events as toggles
	// ------------------------------------------------------------
	logic [2:0] bit_cnt_q;
	logic [6:0] shift_q;
	logic [7:0] link_byte_q;
	logic       link_is_addr_q;
	logic       wr_tgl_q;
	logic       ack_tgl_q;
	logic [7:0] rd_meta_q;
	logic [7:0] rd_byte_q;

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt_q      <= 3'h0;
			shift_q        <= 7'h00;
			link_byte_q    <= rbm_pkg::RESET_BYTE;
			link_is_addr_q <= 1'b0;
			wr_tgl_q       <= 1'b0;
		end else if (byte_wr_i) begin
			shift_q <= {shift_q[5:0], sda_i};
			if (bit_cnt_q == rbm_pkg::BIT_LAST) begin
				link_byte_q    <= {shift_q, sda_i};
				link_is_addr_q <= addr_byte_i;
				wr_tgl_q       <= ~wr_tgl_q;
				bit_cnt_q      <= 3'h0;
			end else begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
			end
		end else begin
			bit_cnt_q <= 3'h0;
		end
	end

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i)
			ack_tgl_q <= 1'b0;
		else if (rd_ack_i)
			ack_tgl_q <= ~ack_tgl_q;
	end

	// read byte is quasi-static: in a frame it changes only after a link byte, an ack or a status flag change, many link edges before use
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_meta_q <= rbm_pkg::RESET_BYTE;
			rd_data_o <= rbm_pkg::RESET_BYTE;
		end else begin
			rd_meta_q <= rd_byte_q;
			rd_data_o <= rd_meta_q;
		end
	end

	// ------------------------------------------------------------
	// core domain synchronisers
	// ------------------------------------------------------------
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic [6:0] prev_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
			prev_q  <= 7'h00;
		end else begin
			sync1_q <= {osc_fail_i, alarm_hit_i, watchdog_timeout_i, centi_tick_i, frame_i, ack_tgl_q, wr_tgl_q};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	logic wr_ev;
	logic ack_ev;
	logic frame_s;
	logic stop_ev;
	logic tick_ev;

	assign wr_ev   = sync2_q[0] ^ prev_q[0];
	assign ack_ev  = sync2_q[1] ^ prev_q[1];
	assign frame_s = sync2_q[2];
	assign stop_ev = prev_q[2] & ~sync2_q[2];
	assign tick_ev = sync2_q[3] & ~prev_q[3];

	// ------------------------------------------------------------
	// pointer, pending clock write, commit
	// ------------------------------------------------------------
	logic [3:0] ptr_q;
	logic       pend_q;
	logic       hit8_q;
	logic       commit;
	logic       data_wr;
	logic       clock_wr;

	assign data_wr  = wr_ev & ~link_is_addr_q;
	assign clock_wr = data_wr & ~ptr_q[3];
	// byte at 7 lands first, commit one cycle later sees it in the buffer
	assign commit   = pend_q & (stop_ev | hit8_q);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_q  <= 4'h0;
			hit8_q <= 1'b0;
		end else begin
			hit8_q <= 1'b0;
			if (wr_ev && link_is_addr_q) begin
				ptr_q <= link_byte_q[3:0];
			end else if (data_wr || ack_ev) begin
				ptr_q  <= ptr_q + 4'h1;
				hit8_q <= (ptr_q == rbm_pkg::LAST_CLOCK);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			pend_q <= 1'b0;
		else if (clock_wr)
			pend_q <= 1'b1;
		else if (commit)
			pend_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// buffer/transfer registers and counters
	// ------------------------------------------------------------
	logic [7:0] buf_q [rbm_pkg::CLOCK_REGS];
	logic [7:0] ctr_q [rbm_pkg::CLOCK_REGS];
	logic [7:0] adv   [rbm_pkg::CLOCK_REGS];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < rbm_pkg::CLOCK_REGS; i++)
				buf_q[i] <= rbm_pkg::RESET_BYTE;
		end else if (clock_wr) begin
			buf_q[ptr_q[2:0]] <= link_byte_q & wmask(ptr_q);
			buf_q[rbm_pkg::REG_SUBSEC[2:0]] <= rbm_pkg::BCD_ZERO;
		end else if (!frame_s && !pend_q) begin
			for (int i = 0; i < rbm_pkg::CLOCK_REGS; i++)
				buf_q[i] <= ctr_q[i];
		end
		// frame active: buffers hold one snapshot for the whole sequence
	end

	// BCD advance by one hundredth
	always_comb begin
		logic [8:0] r;
		logic [8:0] w;
		r = 9'h000;
		w = 9'h000;
		for (int i = 0; i < rbm_pkg::CLOCK_REGS; i++)
			adv[i] = ctr_q[i];
		r = bcd_next(ctr_q[0], rbm_pkg::CENTI_LAST, rbm_pkg::BCD_ZERO);
		adv[0] = r[7:0];
		if (r[8]) begin
			r = bcd_next({1'b0, ctr_q[1][6:0]}, rbm_pkg::MINSEC_LAST, rbm_pkg::BCD_ZERO);
			adv[1] = {ctr_q[1][7], r[6:0]};
		end
		if (r[8]) begin
			r = bcd_next({1'b0, ctr_q[2][6:0]}, rbm_pkg::MINSEC_LAST, rbm_pkg::BCD_ZERO);
			adv[2] = {ctr_q[2][7], r[6:0]};
		end
		if (r[8]) begin
			r = bcd_next({2'b00, ctr_q[3][5:0]}, rbm_pkg::HOUR_LAST, rbm_pkg::BCD_ZERO);
			adv[3] = {2'b00, r[5:0]};
		end
		if (r[8]) begin
			w = bcd_next({5'h00, ctr_q[4][2:0]}, rbm_pkg::DOW_LAST, rbm_pkg::BCD_ONE);
			adv[4] = {ctr_q[4][7:3], w[2:0]};
			r = bcd_next({2'b00, ctr_q[5][5:0]}, month_days(ctr_q[6][4:0], ctr_q[7]), rbm_pkg::BCD_ONE);
			adv[5] = {2'b00, r[5:0]};
		end
		if (r[8]) begin
			r = bcd_next({3'h0, ctr_q[6][4:0]}, rbm_pkg::MONTH_LAST, rbm_pkg::BCD_ONE);
			adv[6] = {ctr_q[6][7:6], 1'b0, r[4:0]};
		end
		if (r[8]) begin
			r = bcd_next(ctr_q[7], rbm_pkg::YEAR_LAST, rbm_pkg::BCD_ZERO);
			adv[7] = r[7:0];
			if (r[8])
				adv[6][7:6] = ctr_q[6][7:6] + 2'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < rbm_pkg::CLOCK_REGS; i++)
				ctr_q[i] <= rbm_pkg::RESET_BYTE;
		end else if (commit) begin
			for (int i = 0; i < rbm_pkg::CLOCK_REGS; i++)
				ctr_q[i] <= buf_q[i];
		end else if (tick_ev && !ctr_q[rbm_pkg::REG_SECONDS[2:0]][rbm_pkg::HALT_BIT]) begin
			for (int i = 0; i < rbm_pkg::CLOCK_REGS; i++)
				ctr_q[i] <= adv[i];
		end
	end

	// divider chain restarts with the loaded time
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			divider_reset_o <= 1'b0;
		else
			divider_reset_o <= commit;
	end

	// ------------------------------------------------------------
	// direct registers 08h-0Eh and status
	// ------------------------------------------------------------
	logic [7:0] dir_q [rbm_pkg::CLOCK_REGS - 1];
	logic [7:0] status;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < rbm_pkg::CLOCK_REGS - 1; i++)
				dir_q[i] <= rbm_pkg::RESET_BYTE;
		end else if (data_wr && ptr_q[3] && ptr_q != rbm_pkg::REG_STATUS) begin
			dir_q[ptr_q[2:0]] <= link_byte_q & wmask(ptr_q);
		end
	end

	// status bits mirror their sources; host writes never reach them
	always_comb begin
		status = rbm_pkg::RESET_BYTE;
		status[rbm_pkg::TIMEOUT_BIT] = sync2_q[4];
		status[rbm_pkg::ALARM_BIT]   = sync2_q[5];
		status[rbm_pkg::FAIL_BIT]    = sync2_q[6];
	end

	// ------------------------------------------------------------
	// read byte at pointer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			rd_byte_q <= rbm_pkg::RESET_BYTE;
		else if (!ptr_q[3])
			rd_byte_q <= buf_q[ptr_q[2:0]];
		else if (ptr_q == rbm_pkg::REG_STATUS)
			rd_byte_q <= status;
		else
			rd_byte_q <= dir_q[ptr_q[2:0]];
	end

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	logic [7:0] trim;
	logic [7:0] almon;

	assign trim  = dir_q[rbm_pkg::REG_TRIM[2:0]];
	assign almon = dir_q[rbm_pkg::REG_ALMON[2:0]];

	assign oscillator_halt_o     = ctr_q[rbm_pkg::REG_SECONDS[2:0]][rbm_pkg::HALT_BIT];
	assign osc_fail_irq_enable_o = ctr_q[rbm_pkg::REG_MINUTES[2:0]][rbm_pkg::FAIL_IRQ_BIT];
	assign square_wave_rate_o    = ctr_q[rbm_pkg::REG_WEEKDAY[2:0]][7:4];
	assign century_bits_o        = ctr_q[rbm_pkg::REG_CENMON[2:0]][7:6];
	assign trim_value_o          = trim[4:0];
	assign trim_sign_o           = trim[rbm_pkg::SIGN_BIT];
	assign idle_level_o          = trim[rbm_pkg::OUT_BIT];
	assign watchdog_resolution_o = {dir_q[1][7], dir_q[1][1:0]};
	assign watchdog_multiplier_o = dir_q[1][6:2];
	assign alarm_irq_enable_o    = almon[rbm_pkg::ALARM_IRQ_BIT];
	assign square_wave_enable_o  = almon[rbm_pkg::WAVE_EN_BIT];
	assign khz_output_enable_o   = almon[rbm_pkg::KHZE_BIT];
	assign alarm_repeat_mode_o   = {dir_q[6][7], dir_q[5][7], dir_q[4][7], dir_q[3][6], dir_q[3][7]};
	assign frozen_o              = frame_s | pend_q;

endmodule

// [tb/rbm_asserts.sv]
// port-level assertions for the rtc register map
`timescale 1ns/1ns
module rbm_asserts #(
	parameter rbm_pkg::rbm_variant_t VARIANT = rbm_pkg::RBM_FULL
) (
	// clock, reset and framing
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       frame_i,
	// clock-control outputs
	input wire logic       divider_reset_o,
	input wire logic       oscillator_halt_o,
	input wire logic       osc_fail_irq_enable_o,
	input wire logic [3:0] square_wave_rate_o,
	input wire logic [1:0] century_bits_o,
	input wire logic       frozen_o,
	// variant-dependent bits
	input wire logic       khz_output_enable_o,
	input wire logic       idle_level_o,
	input wire logic       alarm_irq_enable_o
);
	// ----
	// checks
	// ----
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// control bits only move with the counter load; century bits also step at a year wrap
	property p_ctl_commit;
		$changed({oscillator_halt_o, osc_fail_irq_enable_o, square_wave_rate_o, century_bits_o})
			|-> ##[0:1] divider_reset_o;
	endproperty
	a_ctl_commit: assert property (p_ctl_commit) else $error("control bits moved without a load");
	property p_div_single;
		divider_reset_o |=> !divider_reset_o;
	endproperty
	a_div_single: assert property (p_div_single) else $error("divider reset too long");
	property p_load_frozen;
		divider_reset_o |-> $past(frozen_o, 2);
	endproperty
	a_load_frozen: assert property (p_load_frozen) else $error("load without pending write");
	// sync latency of the frame level is covered by five samples
	property p_freeze;
		frame_i [*5] |-> frozen_o;
	endproperty
	a_freeze: assert property (p_freeze) else $error("buffer not frozen in frame");
	property p_hold;
		frozen_o && frame_i |=> frozen_o;
	endproperty
	a_hold: assert property (p_hold) else $error("snapshot released in frame");
	property p_resume;
		!frame_i [*8] |-> !frozen_o;
	endproperty
	a_resume: assert property (p_resume) else $error("refresh not resumed");
	property p_khz;
		VARIANT == rbm_pkg::RBM_WAVE || !khz_output_enable_o;
	endproperty
	a_khz: assert property (p_khz) else $error("khz enable in wrong variant");
	property p_wave_zero;
		VARIANT != rbm_pkg::RBM_WAVE || !(idle_level_o || alarm_irq_enable_o || osc_fail_irq_enable_o);
	endproperty
	a_wave_zero: assert property (p_wave_zero) else $error("fixed-zero bit set");

	c_commit: cover property (divider_reset_o);
	c_halt: cover property ($rose(oscillator_halt_o));
	c_frozen: cover property (frame_i && frozen_o);
endmodule

bind rbm_regmap rbm_asserts #(.VARIANT(VARIANT)) u_chk (
	.clk_i, .rst_i, .frame_i, .divider_reset_o, .oscillator_halt_o, .osc_fail_irq_enable_o,
	.square_wave_rate_o, .century_bits_o, .frozen_o, .khz_output_enable_o, .idle_level_o,
	.alarm_irq_enable_o
);

// [tb/rbm_host.sv]
// bus host stand-in driving the link side of the register map
`timescale 1ns/1ns
module rbm_host (
	// link clock and framing
	output logic link_clk_o,
	output logic frame_o,
	// byte transfer
	output logic sda_o,
	output logic byte_wr_o,
	output logic addr_byte_o,
	output logic rd_ack_o
);
	// ----
	// link sequencing
	// ----
	initial begin
		link_clk_o  = 1'b0;
		frame_o     = 1'b0;
		sda_o       = 1'b1;
		byte_wr_o   = 1'b0;
		addr_byte_o = 1'b0;
		rd_ack_o    = 1'b0;
	end
	// clock only runs inside these calls, 160 ns period
	task automatic idle(input int n);
		repeat (n) begin
			#80 link_clk_o = 1'b1;
			#80 link_clk_o = 1'b0;
		end
	endtask
	task automatic start_frame();
		sda_o   = 1'b0;
		frame_o = 1'b1;
		#80;
	endtask
	task automatic stop_frame();
		#80 frame_o = 1'b0;
		sda_o = 1'b1;
	endtask
	// msb first, then an ack clock with the line back at its pull-up
	task automatic send(input logic is_addr, input logic [7:0] b);
		addr_byte_o = is_addr;
		byte_wr_o   = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			sda_o = b[i];
			idle(1);
		end
		byte_wr_o   = 1'b0;
		addr_byte_o = 1'b0;
		sda_o       = 1'b1;
		idle(1);
	endtask
	task automatic ack();
		rd_ack_o = 1'b1;
		idle(1);
		rd_ack_o = 1'b0;
	endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the rtc register map
`timescale 1ns/1ns
module tb;
	// ----
	// signals and instances
	// ----
	logic       clk_i, rst_i, link_clk_i, sda_i, frame_i, byte_wr_i, addr_byte_i, rd_ack_i;
	logic       centi_tick_i, watchdog_timeout_i, alarm_hit_i, osc_fail_i, frozen_o;
	logic [7:0] rd_data_o;
	logic       divider_reset_o, oscillator_halt_o, osc_fail_irq_enable_o, square_wave_enable_o;
	logic       khz_output_enable_o, alarm_irq_enable_o, trim_sign_o, idle_level_o;
	logic [3:0] square_wave_rate_o;
	logic [4:0] alarm_repeat_mode_o, watchdog_multiplier_o, trim_value_o;
	logic [2:0] watchdog_resolution_o;
	logic [1:0] century_bits_o;
	int         n_fail = 0;
	int         tests_run = 0;
	int         cycles = 0;

	rbm_regmap #(.VARIANT(rbm_pkg::RBM_FULL)) u_dut (
		.clk_i, .rst_i, .link_clk_i, .sda_i, .frame_i, .byte_wr_i, .addr_byte_i, .rd_ack_i,
		.rd_data_o, .centi_tick_i, .watchdog_timeout_i, .alarm_hit_i, .osc_fail_i,
		.divider_reset_o, .oscillator_halt_o, .osc_fail_irq_enable_o, .square_wave_rate_o,
		.square_wave_enable_o, .khz_output_enable_o, .alarm_irq_enable_o, .alarm_repeat_mode_o,
		.watchdog_multiplier_o, .watchdog_resolution_o, .trim_value_o, .trim_sign_o,
		.idle_level_o, .century_bits_o, .frozen_o
	);
	rbm_host u_host (
		.link_clk_o(link_clk_i), .frame_o(frame_i), .sda_o(sda_i), .byte_wr_o(byte_wr_i),
		.addr_byte_o(addr_byte_i), .rd_ack_o(rd_ack_i)
	);

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ----
	// helpers
	// ----
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic cw(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			cw(3);
			centi_tick_i = 1'b1;
			cw(3);
			centi_tick_i = 1'b0;
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
		u_host.start_frame();
		u_host.send(1'b1, {4'h0, a});
		u_host.idle(8);
		chk(rd_data_o, e, m);
		u_host.stop_frame();
		cw(8);
	endtask
	task automatic w1(input logic [3:0] a, input logic [7:0] d);
		u_host.start_frame();
		u_host.send(1'b1, {4'h0, a});
		u_host.send(1'b0, d);
		u_host.stop_frame();
		cw(8);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_direct();
		u_host.start_frame();
		u_host.send(1'b1, 8'h08);
		u_host.send(1'b0, 8'hff);
		u_host.send(1'b0, 8'ha5);
		u_host.send(1'b0, 8'hff);
		u_host.send(1'b0, 8'h40);
		u_host.send(1'b0, 8'h80);
		u_host.send(1'b0, 8'h00);
		u_host.send(1'b0, 8'h80);
		u_host.stop_frame();
		cw(8);
		chk({1'b0, idle_level_o, trim_sign_o, trim_value_o}, 8'h7f, "trim");
		chk({watchdog_resolution_o, watchdog_multiplier_o}, 8'ha9, "watchdog");
		chk({5'h00, alarm_irq_enable_o, square_wave_enable_o, khz_output_enable_o}, 8'h06, "0ah");
		chk({3'h0, alarm_repeat_mode_o}, 8'h16, "repeat");
		rd(4'h8, 8'hbf, "trim read");
		rd(4'ha, 8'hdf, "0ah read");
	endtask
	task automatic t_status();
		watchdog_timeout_i = 1'b1;
		osc_fail_i = 1'b1;
		w1(4'hf, 8'hff);
		rd(4'hf, 8'h84, "flags");
		watchdog_timeout_i = 1'b0;
		osc_fail_i = 1'b0;
		alarm_hit_i = 1'b1;
		u_host.start_frame();
		u_host.send(1'b1, 8'h0e);
		u_host.idle(8);
		chk(rd_data_o, 8'h80, "0eh read");
		u_host.ack();
		u_host.idle(8);
		chk(rd_data_o, 8'h40, "flags alarm");
		u_host.stop_frame();
		cw(8);
		alarm_hit_i = 1'b0;
	endtask
	task automatic t_commit();
		u_host.start_frame();
		u_host.send(1'b1, 8'h01);
		u_host.send(1'b0, 8'h80);
		u_host.send(1'b0, 8'h80);
		u_host.send(1'b0, 8'h00);
		u_host.send(1'b0, 8'hfb);
		u_host.idle(4);
		chk({6'h00, frozen_o, oscillator_halt_o}, 8'h02, "held");
		u_host.send(1'b0, 8'h01);
		u_host.send(1'b0, 8'hc1);
		u_host.send(1'b0, 8'h00);
		u_host.idle(8);
		chk({oscillator_halt_o, osc_fail_irq_enable_o, century_bits_o, square_wave_rate_o}, 8'hff, "load");
		u_host.stop_frame();
		cw(8);
		rd(4'h4, 8'hf3, "04h read");
		rd(4'h6, 8'hc1, "06h read");
	endtask
	task automatic t_time();
		w1(4'h0, 8'h55);
		tick(3);
		rd(4'h0, 8'h00, "halted");
		w1(4'h1, 8'h00);
		tick(12);
		rd(4'h0, 8'h12, "bcd count");
		u_host.start_frame();
		u_host.send(1'b1, 8'h00);
		u_host.idle(8);
		chk(rd_data_o, 8'h12, "snapshot");
		tick(3);
		u_host.idle(8);
		chk(rd_data_o, 8'h12, "snapshot held");
		u_host.stop_frame();
		cw(8);
		rd(4'h0, 8'h15, "refresh");
	endtask

	initial begin
		rst_i = 1'b1;
		centi_tick_i = 1'b0;
		watchdog_timeout_i = 1'b0;
		alarm_hit_i = 1'b0;
		osc_fail_i = 1'b0;
		#5;
		u_host.idle(1);
		cw(6);
		rst_i = 1'b0;
		cw(2);
		chk({6'h00, frozen_o, oscillator_halt_o}, 8'h00, "after reset");
		rd(4'hf, 8'h00, "flags idle");
		t_direct();
		t_status();
		t_commit();
		t_time();
		complete_run();
	end
endmodule
